// File: rtl/spi_port_defs.svh
/*
 Constants of the serial memory access port: frame layout, space
 selector codes, local register addresses and timing counts.
 Assumes nothing; included by the package, the shifter and the port module.
*/
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH
`define FRAME_BITS 5'h18
`define FRAME_LAST 5'h17
`define REPLY_ZERO_CNT 5'h0B
`define SPACE_TEST 3'h0
`define SPACE_INT_RAM 3'h1
`define SPACE_EXT_SFR 3'h2
`define SPACE_PROGHI 3'h3
`define SPACE_PROG 3'h4
`define SPACE_CACHE 3'h5
`define TEST_BANK_ADDR 8'h0B
`define TEST_IFSEL_ADDR 8'h0C
`define TEST_IFSEL_BIT 1
`define EXT_IFCTRL_ADDR 8'hD0
`define IFCTRL_XCVR_BIT 2
`define IFSEL_TWO_WIRE 2'h1
`define IFSEL_SINGLE_WIRE 2'h2
`define IFSEL_RESET 2'h0
`define SETTLE_TIME_MS 15
`define CLK_MHZ 200
`define SETTLE_CYCLES (`SETTLE_TIME_MS * `CLK_MHZ * 1000)
`endif

// File: rtl/spi_port_pkg.sv
/*
 Types shared by the serial memory access port modules.
 Assumes the constants header is on the include path.
*/
`include "spi_port_defs.svh"
package spi_port_pkg;
    // One serial frame as received, most significant field first
    typedef struct packed {
        logic [2:0] space;
        logic [7:0] addr;
        logic wr;
        logic [7:0] data;
        logic [3:0] unused;
    } frame_s;
    // Request towards the chip's memories
    typedef struct packed {
        logic [2:0] space;
        logic [12:0] addr;
        logic [7:0] bank;
        logic wr;
        logic [7:0] wdata;
    } mem_req_s;
    // Link-domain shifter state
    typedef struct packed {
        logic [4:0] cnt;
        logic [23:0] shift;
        logic done;
        logic out;
        logic oe;
    } shift_state_s;
    // Frame execution sequence
    typedef enum logic [1:0] {IDLE, DECODE, TEST_READ, EXT_WAIT} port_fsm_e;
endpackage

// File: rtl/spi_frame_shifter.sv
/*
 Link-domain shifter: collects 24 bits on rising serial clock and
 shifts the reply byte out. Assumes chip select is its reset and
 that the reply byte is stable while a frame is running.
*/
`timescale 1ns/1ps
`include "spi_port_defs.svh"
module spi_frame_shifter (
    // Link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    // Reply byte held by the system domain
    input wire logic [7:0] rsp_byte,
    // Link outputs and received frame
    output logic serial_out,
    output logic serial_out_oe,
    output logic frame_done,
    output logic [23:0] frame_word
);
    spi_port_pkg::shift_state_s st_reg, st_next; // Whole shifter state
    logic [23:0] reply; // Reply frame, zeros around the byte
    // Next state: shift in, count, pick next reply bit
    always_comb
    begin
        st_next = st_reg;
        reply = {12'h000, rsp_byte, 4'h0};
        // Counting stops at 24 so trailing bits are ignored
        if (st_reg.cnt != `FRAME_BITS)
        begin
            st_next.cnt = st_reg.cnt + 5'h01;
            st_next.shift = {st_reg.shift[22:0], serial_in};
            st_next.oe = 1'b1;
            st_next.out = (st_reg.cnt < `FRAME_LAST) ? reply[5'h16 - st_reg.cnt] : 1'b0;
            st_next.done = (st_reg.cnt == `FRAME_LAST);
        end
    end
    // Chip select high clears everything, output goes undriven
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign serial_out = st_reg.out;
    assign serial_out_oe = st_reg.oe;
    assign frame_done = st_reg.done;
    assign frame_word = st_reg.shift;
    a_done_count: assert property (@(posedge sclk) disable iff (cs_n) frame_done |-> st_reg.cnt == `FRAME_BITS)
        else $error("frame done without 24 bits");
    // Each new bit lands in the low end while older bits move up
    a_msb_first: assert property (@(posedge sclk) disable iff (cs_n)
        st_reg.cnt != 5'h00 && st_reg.cnt != `FRAME_BITS |-> frame_word[0] == $past(serial_in))
        else $error("last bit not in frame lsb");
    a_reply_head: assert property (@(posedge sclk) disable iff (cs_n) st_reg.cnt <= `REPLY_ZERO_CNT |-> !serial_out)
        else $error("reply head not zero");
endmodule

// File: rtl/test_reg_mem.sv
/*
 Small test register store with registered read data.
 Assumes one access per cycle from the system domain.
*/
`timescale 1ns/1ps
module test_reg_mem #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    // Clock and synchronised reset
    input wire logic mclk,
    input wire logic rst_n,
    // Access port
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    typedef struct packed {
        logic [(1<<ADDR_W)-1:0][DATA_W-1:0] mem;
        logic [DATA_W-1:0] rd;
    } mem_state_s;
    mem_state_s st_reg, st_next; // Contents and read register
    // Read the old word first, then write
    always_comb
    begin
        st_next = st_reg;
        st_next.rd = st_reg.mem[addr];
        if (we)
            st_next.mem[addr] = wdata;
    end
    // Register the store
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign rdata = st_reg.rd;
endmodule

// File: rtl/spi_mem_access_port.sv
/*
 Serial slave memory access port, system side. Decodes received
 frames, serves local test and interface registers, forwards other
 spaces as requests to the chip's memories and drives the shared
 pin switches. Assumes the memory side answers each request with a
 one-cycle ack and that the master keeps chip select low briefly
 after the last bit so the frame can be picked up.
*/
`timescale 1ns/1ps
`include "spi_port_defs.svh"
module spi_mem_access_port #(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter int TEST_ADDR_W = 4
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Memory request towards the chip
    output spi_port_pkg::mem_req_s mem_req,
    output logic mem_req_valid,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // Interface ownership and pin switches
    output logic port_owns_memory,
    output logic single_wire_ctrl_on,
    output logic two_wire_select,
    output logic transceiver_on,
    output logic analog_driver_on,
    output logic link_settling
);
    // Complete state of the system side
    typedef struct packed {
        spi_port_pkg::port_fsm_e fsm;
        logic [2:0] done_sync;
        spi_port_pkg::frame_s frame;
        logic if_sel;
        logic [7:0] bank;
        logic [4:0] prog_hi;
        logic [1:0] ifc_sel;
        logic xcvr_en;
        logic [7:0] rsp;
        spi_port_pkg::mem_req_s req;
        logic req_valid;
        logic [21:0] settle_cnt;
        logic settling;
        logic sw_on;
        logic tw_sel;
        logic xcvr_on;
        logic ana_on;
    } port_state_s;

    port_state_s st_reg, st_next; // Registered state and its next value
    logic [1:0] rst_sync; // Reset release synchroniser
    logic rst_q_n; // Synchronised reset of the system-side state and the test store; the shifter resets on chip select
    logic frame_done; // Link-domain frame level
    logic [23:0] frame_word; // Link-domain frame, stable after done
    logic frame_seen; // One-cycle event of a new frame
    logic allowed; // Space reachable under current ownership
    logic undef_space; // Selector outside the defined codes
    logic is_local; // Served without the memory request
    logic [7:0] local_val; // Read value of a local register
    logic tm_we; // Test store write strobe
    logic [TEST_ADDR_W-1:0] tm_addr; // Test store address
    logic [7:0] tm_wdata; // Test store write data
    logic [7:0] tm_rdata; // Test store read data
    logic tm_hit; // Address falls inside the test store

    // Settling count width must hold the parameter
    localparam logic [21:0] SETTLE_LOAD = 22'(SETTLE_CYCLES - 1);

    // Release reset through two flops, assert it at once
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_q_n = rst_sync[1];

    // Link-side shifter on the master's clock
    spi_frame_shifter u_shifter (
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .rsp_byte(st_reg.rsp),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .frame_done(frame_done),
        .frame_word(frame_word)
    );

    // Local test registers outside the bank and ownership bits
    test_reg_mem #(
        .ADDR_W(TEST_ADDR_W),
        .DATA_W(8)
    ) u_test_mem (
        .mclk(mclk),
        .rst_n(rst_q_n),
        .we(tm_we),
        .addr(tm_addr),
        .wdata(tm_wdata),
        .rdata(tm_rdata)
    );

    // Rising edge of the synchronised done level; stage 0 feeds stage 1 only
    assign frame_seen = st_reg.done_sync[1] & ~st_reg.done_sync[2];

    // Next-state logic of the whole port
    always_comb
    begin
        st_next = st_reg;
        allowed = 1'b0;
        undef_space = 1'b0;
        is_local = 1'b0;
        local_val = 8'h00;
        tm_we = 1'b0;
        tm_addr = st_reg.frame.addr[TEST_ADDR_W-1:0];
        tm_wdata = st_reg.frame.data;
        tm_hit = (st_reg.frame.addr >> TEST_ADDR_W) == 8'h00;
        st_next.done_sync = {st_reg.done_sync[1:0], frame_done};

        // Gate the frame by ownership and selector
        allowed = st_reg.if_sel || (st_reg.frame.space == `SPACE_TEST);
        undef_space = (st_reg.frame.space > `SPACE_CACHE);

        unique case (st_reg.fsm)
            spi_port_pkg::IDLE:
            begin
                // Frames seen while busy are lost; master must pace them
                if (frame_seen)
                begin
                    st_next.frame = frame_word;
                    st_next.fsm = spi_port_pkg::DECODE;
                end
            end
            spi_port_pkg::DECODE:
            begin
                st_next.fsm = spi_port_pkg::IDLE;
                if (!allowed || undef_space)
                begin
                    // Blocked or unknown: nothing touched, reply zero
                    st_next.rsp = 8'h00;
                end
                else
                begin
                    unique case (st_reg.frame.space)
                        `SPACE_TEST:
                        begin
                            if (st_reg.frame.addr == `TEST_BANK_ADDR)
                            begin
                                is_local = 1'b1;
                                local_val = st_reg.bank;
                                if (st_reg.frame.wr)
                                    st_next.bank = st_reg.frame.data;
                            end
                            else if (st_reg.frame.addr == `TEST_IFSEL_ADDR)
                            begin
                                is_local = 1'b1;
                                local_val = 8'(st_reg.if_sel) << `TEST_IFSEL_BIT;
                                if (st_reg.frame.wr)
                                    st_next.if_sel = st_reg.frame.data[`TEST_IFSEL_BIT];
                            end
                            else if (!tm_hit)
                            begin
                                // Holes in the test space read zero
                                is_local = 1'b1;
                            end
                            else if (st_reg.frame.wr)
                            begin
                                is_local = 1'b1;
                                tm_we = 1'b1;
                            end
                            else
                            begin
                                st_next.fsm = spi_port_pkg::TEST_READ;
                            end
                        end
                        `SPACE_EXT_SFR:
                        begin
                            if (st_reg.frame.addr == `EXT_IFCTRL_ADDR)
                            begin
                                is_local = 1'b1;
                                local_val = {5'h00, st_reg.xcvr_en, st_reg.ifc_sel};
                                if (st_reg.frame.wr)
                                begin
                                    // Both fields land in the same write
                                    st_next.ifc_sel = st_reg.frame.data[1:0];
                                    st_next.xcvr_en = st_reg.frame.data[`IFCTRL_XCVR_BIT];
                                end
                            end
                        end
                        `SPACE_PROGHI:
                        begin
                            is_local = 1'b1;
                            local_val = {3'h0, st_reg.prog_hi};
                            if (st_reg.frame.wr)
                                st_next.prog_hi = st_reg.frame.data[4:0];
                        end
                        default:
                        begin
                            is_local = 1'b0;
                        end
                    endcase

                    if (is_local)
                    begin
                        // Writes leave a zero reply, reads the value
                        st_next.rsp = st_reg.frame.wr ? 8'h00 : local_val;
                    end
                    else if (st_next.fsm == spi_port_pkg::IDLE)
                    begin
                        // Remote space: hand the access to the chip
                        st_next.req.space = st_reg.frame.space;
                        st_next.req.addr = {5'h00, st_reg.frame.addr};
                        if (st_reg.frame.space == `SPACE_PROG)
                            st_next.req.addr = {st_reg.prog_hi, st_reg.frame.addr};
                        st_next.req.bank = st_reg.bank;
                        st_next.req.wr = st_reg.frame.wr;
                        st_next.req.wdata = st_reg.frame.data;
                        st_next.req_valid = 1'b1;
                        st_next.fsm = spi_port_pkg::EXT_WAIT;
                    end
                end
            end
            spi_port_pkg::TEST_READ:
            begin
                // Store read data arrives one cycle after the address
                st_next.rsp = tm_rdata;
                st_next.fsm = spi_port_pkg::IDLE;
            end
            spi_port_pkg::EXT_WAIT:
            begin
                // No timeout: a memory that never acks stalls the port
                if (mem_ack)
                begin
                    st_next.req_valid = 1'b0;
                    st_next.rsp = st_reg.req.wr ? 8'h00 : mem_rdata;
                    st_next.fsm = spi_port_pkg::IDLE;
                end
            end
        endcase

        // Pin switches follow the control fields in either order
        st_next.sw_on = (st_next.ifc_sel == `IFSEL_SINGLE_WIRE);
        st_next.tw_sel = (st_next.ifc_sel == `IFSEL_TWO_WIRE);
        st_next.xcvr_on = st_next.xcvr_en;
        // Analog driver only when neither path claims the pin
        st_next.ana_on = !st_next.sw_on && !st_next.xcvr_en;

        // Changeover window after the pin goes to the transceiver
        if (st_next.xcvr_on && !st_reg.xcvr_on)
        begin
            st_next.settle_cnt = SETTLE_LOAD;
            st_next.settling = 1'b1;
        end
        else if (!st_next.xcvr_on)
        begin
            st_next.settle_cnt = 22'h000000;
            st_next.settling = 1'b0;
        end
        else if (st_reg.settle_cnt != 22'h000000)
        begin
            st_next.settle_cnt = st_reg.settle_cnt - 22'h000001;
        end
        else
        begin
            st_next.settling = 1'b0;
        end
    end

    // Register the whole state; control bits reset to known values
    always_ff @(posedge mclk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            st_reg <= '0;
            st_reg.ifc_sel <= `IFSEL_RESET;
            st_reg.ana_on <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign mem_req = st_reg.req;
    assign mem_req_valid = st_reg.req_valid;
    assign port_owns_memory = st_reg.if_sel;
    assign single_wire_ctrl_on = st_reg.sw_on;
    assign two_wire_select = st_reg.tw_sel;
    assign transceiver_on = st_reg.xcvr_on;
    assign analog_driver_on = st_reg.ana_on;
    assign link_settling = st_reg.settling;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_q_n);

    // Decode step followed by a remote request
    sequence s_remote_issue;
        st_reg.fsm == spi_port_pkg::DECODE && allowed && !undef_space && !is_local
            && st_next.fsm == spi_port_pkg::EXT_WAIT;
    endsequence
    sequence s_read_ack;
        mem_req_valid && !mem_req.wr && mem_ack;
    endsequence

    a_blocked_space: assert property (st_reg.fsm == spi_port_pkg::DECODE && !allowed
        |=> !mem_req_valid && st_reg.rsp == 8'h00)
        else $error("blocked space reached memory");
    a_undef_ignored: assert property (st_reg.fsm == spi_port_pkg::DECODE && undef_space
        |=> !mem_req_valid && st_reg.rsp == 8'h00 && $stable(st_reg.bank))
        else $error("undefined selector acted");
    a_prog_address: assert property ($rose(mem_req_valid) && mem_req.space == `SPACE_PROG
        |-> mem_req.addr == {st_reg.prog_hi, st_reg.frame.addr})
        else $error("program address not concatenated");
    a_cache_bank: assert property ($rose(mem_req_valid) && mem_req.space == `SPACE_CACHE
        |-> mem_req.bank == st_reg.bank)
        else $error("cache access without chosen bank");
    a_high_load: assert property (st_reg.fsm == spi_port_pkg::DECODE && allowed
        && st_reg.frame.space == `SPACE_PROGHI && st_reg.frame.wr
        |=> st_reg.prog_hi == $past(st_reg.frame.data[4:0]))
        else $error("high address not loaded");
    a_read_reply: assert property (s_remote_issue ##[1:64] s_read_ack
        |=> st_reg.rsp == $past(mem_rdata))
        else $error("read byte not held for next frame");
    a_pin_exclusive: assert property (!(analog_driver_on && (transceiver_on || single_wire_ctrl_on)))
        else $error("analog driver fights single-wire path");
    // The driver flop follows the fields of the same cycle, so a write that claims the pin is not flagged
    a_deact_done: assert property (st_reg.ifc_sel != `IFSEL_SINGLE_WIRE && !st_reg.xcvr_en
        |-> analog_driver_on)
        else $error("analog driver not restored");
    a_settle_start: assert property ($rose(transceiver_on) |-> link_settling)
        else $error("no settling window after switch");
endmodule

// File: verif/serial_master_model.sv
/*
 Serial master model: sends frames most significant bit first on a
 30 ns link clock and collects the reply bits.
 Assumes the slave samples on rising clock and changes its output there.
*/
`timescale 1ns/1ps
module serial_master_model (
    // Link lines driven by the master
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    // Reply line from the slave
    input wire logic serial_out
);
    // Idle: clock parked low, select high
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // One frame of n bits; the clock runs only inside frames, phase unrelated to mclk
    task automatic xfer(input logic [23:0] f, input int n, output logic [23:0] r);
        r = 24'h000000;
        cs_n = 1'b0;
        for (int i = 23; i > 23 - n; i--)
        begin
            serial_in = f[i];
            #15;
            r[i] = serial_out;
            sclk = 1'b1;
            #15;
            sclk = 1'b0;
        end
        // Hold select past the last edge so the frame is picked up
        #30;
        cs_n = 1'b1;
        // Released line: show a changed level, not the stale bit
        serial_in = ~serial_in;
        #45;
    endtask
endmodule

// File: verif/spi_slave_memory_access_port_tb_top.sv
/*
 Testbench of the serial memory access port: a row table of frames
 with expected replies and pin states, then a changeover, a short-frame and a reset case.
 Assumes the design package and the master model are compiled first.
*/
`timescale 1ns/1ps
module spi_slave_memory_access_port_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic mem_ack = 1'b0;
    logic [7:0] mem_rdata = 8'h00;
    logic [1:0] lat = 2'h0; // Memory wait counter
    logic sclk, cs_n, serial_in, serial_out, serial_out_oe, mem_req_valid, port_owns_memory;
    logic single_wire_ctrl_on, two_wire_select, transceiver_on, analog_driver_on, link_settling;
    spi_port_pkg::mem_req_s mem_req;
    wire [3:0] pins = {single_wire_ctrl_on, two_wire_select, transceiver_on, analog_driver_on};
    wire reply_line = serial_out_oe ? serial_out : 1'b0; // Weak pull-down while the slave releases the line
    logic [20:0] wr_seen = 21'h1FFFFF; // Address and data of the last remote write
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [35:0] rows [$]; // Frame, expected reply byte, expected pins
    logic [23:0] rep;
    // System clock, 200 MHz
    always #2.5 mclk = ~mclk;
    spi_mem_access_port #(.SETTLE_CYCLES(20)) dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .mem_req(mem_req), .mem_req_valid(mem_req_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .port_owns_memory(port_owns_memory), .single_wire_ctrl_on(single_wire_ctrl_on),
        .two_wire_select(two_wire_select), .transceiver_on(transceiver_on),
        .analog_driver_on(analog_driver_on), .link_settling(link_settling));
    serial_master_model master_u (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(reply_line));
    // Memory side: acks after a wait; returns the last remote write at its address,
    // otherwise data mixing the address and the bank so a wrong address shows
    always @(negedge mclk)
    begin
        mem_ack <= 1'b0;
        if (mem_req_valid && !mem_ack)
        begin
            lat <= lat + 2'h1;
            if (lat == 2'h3)
            begin
                mem_ack <= 1'b1;
                if (mem_req.wr)
                    wr_seen <= {mem_req.addr, mem_req.wdata};
                if (wr_seen[20:8] == mem_req.addr)
                    mem_rdata <= wr_seen[7:0];
                else
                    mem_rdata <= mem_req.addr[7:0] ^ {3'h0, mem_req.addr[12:8]} ^ mem_req.bank ^ 8'h5A;
            end
        end
    end
    // Compare and count
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard, well above the expected 4300 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            stop_test;
        end
    end
    function automatic logic [23:0] fr(input logic [2:0] s, input logic [7:0] a, input logic w, input logic [7:0] d);
        return {s, a, w, d, 4'h0};
    endfunction
    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({16'h0, port_owns_memory, link_settling, mem_req_valid, serial_out_oe, pins}, 24'h1);
        rows.push_back({fr(3'h1, 8'h10, 1'b0, 8'h00), 8'h00, 4'h1});
        rows.push_back({fr(3'h0, 8'h03, 1'b1, 8'hA5), 8'h00, 4'h1});
        rows.push_back({fr(3'h0, 8'h03, 1'b0, 8'h00), 8'h00, 4'h1});
        rows.push_back({fr(3'h0, 8'h0C, 1'b1, 8'h02), 8'hA5, 4'h1});
        rows.push_back({fr(3'h1, 8'h10, 1'b0, 8'h00), 8'h00, 4'h1});
        rows.push_back({fr(3'h3, 8'h00, 1'b1, 8'h17), 8'h4A, 4'h1});
        rows.push_back({fr(3'h4, 8'h65, 1'b0, 8'h00), 8'h00, 4'h1});
        rows.push_back({fr(3'h0, 8'h0B, 1'b1, 8'h04), 8'h28, 4'h1});
        rows.push_back({fr(3'h5, 8'h02, 1'b0, 8'h00), 8'h00, 4'h1});
        rows.push_back({fr(3'h6, 8'h0B, 1'b1, 8'hFF), 8'h5C, 4'h1});
        rows.push_back({fr(3'h0, 8'h0B, 1'b0, 8'h00), 8'h00, 4'h1});
        rows.push_back({fr(3'h2, 8'hD0, 1'b1, 8'h06), 8'h04, 4'hA});
        rows.push_back({fr(3'h2, 8'hD0, 1'b1, 8'h02), 8'h00, 4'h8});
        rows.push_back({fr(3'h2, 8'hD0, 1'b1, 8'h05), 8'h00, 4'h6});
        rows.push_back({fr(3'h2, 8'hD0, 1'b1, 8'h01), 8'h00, 4'h5});
        rows.push_back({fr(3'h1, 8'h7F, 1'b1, 8'h34), 8'h00, 4'h5});
        rows.push_back({fr(3'h1, 8'h7F, 1'b0, 8'h00), 8'h00, 4'h5});
        rows.push_back({fr(3'h0, 8'h0B, 1'b0, 8'h00), 8'h34, 4'h5});
        foreach (rows[i])
        begin
            master_u.xfer(rows[i][35:12], 24, rep);
            #200;
            check(rep, {12'h0, rows[i][11:4], 4'h0});
            check({19'h0, serial_out_oe, pins}, {19'h0, 1'b0, rows[i][3:0]});
        end
        check({23'h0, port_owns_memory}, 24'h1);
        // Transceiver on by itself opens the changeover window; the master waits it out
        master_u.xfer(fr(3'h2, 8'hD0, 1'b1, 8'h04), 24, rep);
        check(rep, {12'h0, 8'h04, 4'h0});
        check({19'h0, link_settling, pins}, {19'h0, 1'b1, 4'h2});
        #200;
        check({23'h0, link_settling}, 24'h0);
        // Frame cut short after 10 bits must not overwrite the stored byte
        master_u.xfer(fr(3'h0, 8'h03, 1'b1, 8'hFF), 10, rep);
        #200;
        master_u.xfer(fr(3'h0, 8'h03, 1'b0, 8'h00), 24, rep);
        #200;
        master_u.xfer(24'h0, 24, rep);
        #200;
        check(rep, {12'h0, 8'hA5, 4'h0});
        // Reset in mid-run returns ownership and the pin switches to their reset values
        @(negedge mclk) rst_n = 1'b0;
        @(negedge mclk);
        check({16'h0, port_owns_memory, link_settling, mem_req_valid, serial_out_oe, pins}, 24'h1);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({16'h0, port_owns_memory, link_settling, mem_req_valid, serial_out_oe, pins}, 24'h1);
        stop_test;
    end
endmodule
